// ===== design/le_pkg.sv
`default_nettype none
package le_pkg;

    // Gate functions of one equation
    typedef enum logic [1:0] {
        LE_GATE_AND  = 2'h0,
        LE_GATE_OR   = 2'h1,
        LE_GATE_NAND = 2'h2,
        LE_GATE_NOR  = 2'h3
    } le_gate_e;

    localparam int          LE_IN_N   = 4;
    localparam int          LE_SEL_W  = 8;
    localparam int          LE_DLY_W  = 24;
    localparam int          LE_ADDR_W = 12;

    // Register byte addresses
    localparam logic [11:0] LE_REG_EQ_COUNT = 12'h000;
    localparam logic [11:0] LE_REG_PASS     = 12'h004;
    localparam logic [11:0] LE_EQ_BASE      = 12'h100;
    localparam int          LE_EQ_SHIFT     = 5;

    // Word index inside one equation block
    localparam logic [2:0]  LE_F_CTRL  = 3'h0;
    localparam logic [2:0]  LE_F_SEL   = 3'h1;
    localparam logic [2:0]  LE_F_RST   = 3'h2;
    localparam logic [2:0]  LE_F_ON    = 3'h3;
    localparam logic [2:0]  LE_F_OFF   = 3'h4;
    localparam logic [2:0]  LE_F_STAT  = 3'h5;

    // Control and status word bit positions
    localparam int          LE_CTRL_GATE   = 0;
    localparam int          LE_CTRL_INV    = 2;
    localparam int          LE_CTRL_INVSET = 6;
    localparam int          LE_CTRL_INVRST = 7;
    localparam int          LE_STAT_UNL    = 0;
    localparam int          LE_STAT_LAT    = 1;

    // Equation count choices
    localparam logic [6:0]  LE_CNT_0   = 7'h00;
    localparam logic [6:0]  LE_CNT_5   = 7'h05;
    localparam logic [6:0]  LE_CNT_10  = 7'h0A;
    localparam logic [6:0]  LE_CNT_20  = 7'h14;
    localparam logic [6:0]  LE_CNT_40  = 7'h28;
    localparam logic [6:0]  LE_CNT_80  = 7'h50;
    localparam logic [6:0]  LE_CNT_RST = LE_CNT_20;

    // Settings of one equation
    typedef struct packed {
        le_gate_e                            gate;
        logic [LE_IN_N-1:0]                  inv;
        logic                                inv_set;
        logic                                inv_rst;
        logic [LE_IN_N-1:0][LE_SEL_W-1:0]    sel;
        logic [LE_SEL_W-1:0]                 rst_sel;
        logic [LE_DLY_W-1:0]                 on_dly;
        logic [LE_DLY_W-1:0]                 off_dly;
    } le_cfg_s;

    // Running state of one equation
    typedef struct packed {
        logic [LE_DLY_W-1:0] cnt;
        logic                unl;
        logic                lat;
    } le_state_s;

endpackage
`default_nettype wire

// ===== design/le_select.sv
`timescale 1ns/1ps
`default_nettype none
module le_select #(
    parameter int SIG_N = 193
) (
    // Signal list and choice
    input  wire logic [SIG_N-1:0]            sig_all,
    input  wire logic [le_pkg::LE_SEL_W-1:0] sel,
    input  wire logic                        inv,
    // Picked value
    output logic                             val,
    output logic                             used
);
    wire raw = (int'(sel) < SIG_N) ? sig_all[sel] : 1'b0;

    // Code zero means no source assigned
    assign used = (sel != '0);
    // Negation only acts on an assigned source
    assign val  = used & (raw ^ inv); // RQ2 RQ12
endmodule
`default_nettype wire

// ===== design/le_eval.sv
`timescale 1ns/1ps
`default_nettype none
module le_eval (
    // Settings and inputs
    input  wire le_pkg::le_cfg_s              cfg,
    input  wire le_pkg::le_state_s            cur,
    input  wire logic [le_pkg::LE_IN_N-1:0]   in_val,
    input  wire logic [le_pkg::LE_IN_N-1:0]   in_used,
    input  wire logic                         rst_act,
    // Next state
    output le_pkg::le_state_s                 nxt
);
    wire [le_pkg::LE_IN_N-1:0] and_in = in_val | ~in_used;
    wire [le_pkg::LE_IN_N-1:0] or_in  = in_val & in_used;
    wire and_r = &and_in; // RQ13
    wire or_r  = |or_in; // RQ13
    logic g;
    always_comb begin
        case (cfg.gate)
            le_pkg::LE_GATE_AND:  g = and_r;
            le_pkg::LE_GATE_OR:   g = or_r;
            le_pkg::LE_GATE_NAND: g = ~and_r;
            le_pkg::LE_GATE_NOR:  g = ~or_r;
            default:              g = and_r;
        endcase
    end

    // Delay counted in evaluation passes
    wire [le_pkg::LE_DLY_W-1:0] target = g ? cfg.on_dly : cfg.off_dly; // RQ3
    wire                        moving = (g != cur.unl);
    wire                        expire = moving && (cur.cnt >= target);
    wire                        unl_n  = expire ? g : cur.unl; // RQ3 RQ4
    wire                        set_n  = unl_n ^ cfg.inv_set; // RQ5

    always_comb begin
        nxt.unl = unl_n;
        nxt.cnt = (moving && !expire) ? cur.cnt + 1'b1 : '0; // RQ3
        // Reset wins over set
        nxt.lat = rst_act ? 1'b0 : (set_n | cur.lat); // RQ4 RQ6 RQ14
    end
endmodule
`default_nettype wire

// ===== design/le_bank.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1 - Each equation takes four inputs chosen from the signal list.
// RQ2 - Each of the four inputs has its own negation option.
// RQ3 - Gate result passes on and off delay timer.
// RQ4 - Timer gives an unlatched and a latched output.
// RQ5 - Latch set signal may be inverted.
// RQ6 - Latch cleared only by assigned reset source; none assigned, never cleared. Code also clears it on srst and for equations beyond the count.
// RQ7 - Latch reset source may be inverted.
// RQ8 - Equations evaluated one to highest, pass repeated continuously.
// RQ9 - Lower equation output change seen by higher one same pass.
// RQ10 - Higher equation output change seen by lower one next pass.
// RQ11 - Equation count selectable 0, 5, 10, 20, 40, 80; default 20.
// RQ12 - Input negation acts only when a source is assigned.
// RQ13 - Gate is AND, OR, NAND or NOR; unassigned inputs neutral.
// RQ14 - Latch sets on set true, holds until reset; reset wins.
module le_bank #(
    parameter int MAX_EQ = 80,
    parameter int EXT_N  = 32
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          srst,
    // Register port
    input  wire logic [le_pkg::LE_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]                   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [31:0]                        reg_rdata,
    // Signals from protection functions
    input  wire logic [EXT_N-1:0]              ext_sig,
    // Equation outputs
    output logic [MAX_EQ-1:0]                  eq_unlatched,
    output logic [MAX_EQ-1:0]                  eq_latched,
    output logic                               pass_done
);
    localparam int SIG_N = 1 + EXT_N + 2 * MAX_EQ;
    localparam int IDX_W = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    le_pkg::le_cfg_s   cfg [MAX_EQ];
    le_pkg::le_state_s st  [MAX_EQ];
    logic [IDX_W-1:0]  equation_count;
    logic [IDX_W-1:0]  idx;
    logic [31:0]       pass_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    // Outputs are kept in the same vector the selectors read, so a lower
    // equation written earlier in this pass is already visible above it,
    // while a higher one still shows last pass's value.
    wire [SIG_N-1:0] sig_all = {eq_latched, eq_unlatched, ext_sig, 1'b0}; // RQ9 RQ10
    wire             run     = (equation_count != '0);
    wire             last    = (idx >= equation_count - 1'b1);
    wire [IDX_W-1:0] next_idx = (!run || last) ? '0 : idx + 1'b1; // RQ8

    le_pkg::le_cfg_s   cur_cfg;
    le_pkg::le_state_s cur_st;
    le_pkg::le_state_s next_st;
    logic [le_pkg::LE_IN_N-1:0] in_val;
    logic [le_pkg::LE_IN_N-1:0] in_used;
    logic rst_val;
    logic rst_used;

    assign cur_cfg = cfg[idx];
    assign cur_st  = st[idx];

    genvar k;
    generate
        for (k = 0; k < le_pkg::LE_IN_N; k++) begin : g_in
            le_select #(.SIG_N(SIG_N)) u_sel (
                .sig_all (sig_all),
                .sel     (cur_cfg.sel[k]),
                .inv     (cur_cfg.inv[k]),
                .val     (in_val[k]),
                .used    (in_used[k])
            ); // RQ1
        end
    endgenerate

    le_select #(.SIG_N(SIG_N)) u_rst_sel (
        .sig_all (sig_all),
        .sel     (cur_cfg.rst_sel),
        .inv     (cur_cfg.inv_rst),
        .val     (rst_val),
        .used    (rst_used)
    ); // RQ6 RQ7

    le_eval u_eval (
        .cfg     (cur_cfg),
        .cur     (cur_st),
        .in_val  (in_val),
        .in_used (in_used),
        .rst_act (rst_val & rst_used),
        .nxt     (next_st)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire [le_pkg::LE_ADDR_W-1:0] eq_off   = reg_addr - le_pkg::LE_EQ_BASE;
    wire [IDX_W-1:0]             eq_sel   = eq_off[le_pkg::LE_ADDR_W-1:le_pkg::LE_EQ_SHIFT];
    wire [2:0]                   field    = reg_addr[4:2];
    wire                         in_eq    = (reg_addr >= le_pkg::LE_EQ_BASE) && (int'(eq_sel) < MAX_EQ);
    // Byte lanes are ignored, so any address inside the word hits it
    wire                         hit_cnt  = (reg_addr[le_pkg::LE_ADDR_W-1:2] == le_pkg::LE_REG_EQ_COUNT[le_pkg::LE_ADDR_W-1:2]);
    wire                         hit_pass = (reg_addr[le_pkg::LE_ADDR_W-1:2] == le_pkg::LE_REG_PASS[le_pkg::LE_ADDR_W-1:2]);
    wire [IDX_W-1:0]             wr_cnt   = reg_wdata[IDX_W-1:0];
    // Only the listed counts are accepted and they may not exceed the build
    wire cnt_legal = (reg_wdata[31:IDX_W] == '0) && (int'(wr_cnt) <= MAX_EQ) &&
                     (wr_cnt == le_pkg::LE_CNT_0  || wr_cnt == le_pkg::LE_CNT_5  ||
                      wr_cnt == le_pkg::LE_CNT_10 || wr_cnt == le_pkg::LE_CNT_20 ||
                      wr_cnt == le_pkg::LE_CNT_40 || wr_cnt == le_pkg::LE_CNT_80); // RQ11
    wire cfg_wr = reg_wr && in_eq;

    le_pkg::le_cfg_s rd_cfg;
    assign rd_cfg = cfg[in_eq ? eq_sel : '0];

    wire [31:0] rd_ctrl = {24'h000000, rd_cfg.inv_rst, rd_cfg.inv_set, rd_cfg.inv, rd_cfg.gate};
    wire [31:0] rd_stat = {30'h00000000, eq_latched[eq_sel], eq_unlatched[eq_sel]};
    wire [31:0] rd_eq   = (field == le_pkg::LE_F_CTRL) ? rd_ctrl :
                          (field == le_pkg::LE_F_SEL)  ? rd_cfg.sel :
                          (field == le_pkg::LE_F_RST)  ? {24'h000000, rd_cfg.rst_sel} :
                          (field == le_pkg::LE_F_ON)   ? {8'h00, rd_cfg.on_dly} :
                          (field == le_pkg::LE_F_OFF)  ? {8'h00, rd_cfg.off_dly} :
                          (field == le_pkg::LE_F_STAT) ? rd_stat : 32'h00000000;
    wire [31:0] rd_word = hit_cnt  ? {25'h0000000, equation_count} :
                          hit_pass ? pass_cnt :
                          in_eq    ? rd_eq : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata      <= 32'h00000000;
            equation_count <= le_pkg::LE_CNT_RST; // RQ11
        end else begin
            reg_rdata <= reg_rd ? rd_word : 32'h00000000;
            if (reg_wr && hit_cnt && cnt_legal) begin
                equation_count <= wr_cnt; // RQ11
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < MAX_EQ; i++) begin
            if (srst) begin
                cfg[i] <= '0;
            end else if (cfg_wr && int'(eq_sel) == i) begin
                case (field)
                    le_pkg::LE_F_CTRL: begin
                        cfg[i].gate    <= le_pkg::le_gate_e'(reg_wdata[le_pkg::LE_CTRL_GATE +: 2]); // RQ13
                        cfg[i].inv     <= reg_wdata[le_pkg::LE_CTRL_INV +: le_pkg::LE_IN_N]; // RQ2
                        cfg[i].inv_set <= reg_wdata[le_pkg::LE_CTRL_INVSET]; // RQ5
                        cfg[i].inv_rst <= reg_wdata[le_pkg::LE_CTRL_INVRST]; // RQ7
                    end
                    le_pkg::LE_F_SEL: cfg[i].sel     <= reg_wdata; // RQ1
                    le_pkg::LE_F_RST: cfg[i].rst_sel <= reg_wdata[le_pkg::LE_SEL_W-1:0]; // RQ6
                    le_pkg::LE_F_ON:  cfg[i].on_dly  <= reg_wdata[le_pkg::LE_DLY_W-1:0]; // RQ3
                    le_pkg::LE_F_OFF: cfg[i].off_dly <= reg_wdata[le_pkg::LE_DLY_W-1:0]; // RQ3
                    default: cfg[i] <= cfg[i];
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Evaluation
    always_ff @(posedge core_clk) begin
        if (srst) begin
            idx       <= '0;
            pass_cnt  <= 32'h00000000;
            pass_done <= 1'b0;
        end else begin
            idx       <= next_idx; // RQ8
            pass_done <= run && last;
            if (run && last) begin
                pass_cnt <= pass_cnt + 32'h00000001;
            end
        end
    end

    // Equations beyond the current count are held cleared
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < MAX_EQ; i++) begin
            if (srst || i >= int'(equation_count)) begin
                st[i]           <= '0;
                eq_unlatched[i] <= 1'b0;
                eq_latched[i]   <= 1'b0;
            end else if (run && int'(idx) == i) begin
                st[i]           <= next_st; // RQ8
                eq_unlatched[i] <= next_st.unl; // RQ4
                eq_latched[i]   <= next_st.lat; // RQ4 RQ14
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/le_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module le_bank_monitor #(
    parameter int MAX_EQ = 80
) (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         srst,
    // Register port
    input  wire logic [le_pkg::LE_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [31:0]                  reg_rdata,
    // Equation outputs
    input  wire logic [MAX_EQ-1:0]            eq_unlatched,
    input  wire logic [MAX_EQ-1:0]            eq_latched,
    input  wire logic                         pass_done
);
    logic [6:0]        shadow;
    logic [7:0]        gap;
    logic [1:0]        seen;
    logic [1:0]        quiet;
    wire               cnt_wr  = reg_wr && (reg_addr[11:2] == 10'h000);
    wire  [6:0]        wv      = reg_wdata[6:0];
    wire               legal   = (wv == 7'h00 || wv == 7'h05 || wv == 7'h0A || wv == 7'h14 || wv == 7'h28
                                  || wv == 7'h50) && (wv <= MAX_EQ) && (reg_wdata[31:7] == '0);
    wire  [MAX_EQ-1:0] hi_mask = {MAX_EQ{1'b1}} << shadow;
    // Pass length is judged only after two pass end pulses since a count write, as the first pass after it may be odd
    always_ff @(posedge core_clk) begin
        if (srst) begin
            shadow <= 7'h14;
            gap    <= 8'h00;
            seen   <= 2'h0;
            quiet  <= 2'h0;
        end else begin
            if (cnt_wr && legal) shadow <= wv;
            gap   <= pass_done ? 8'h01 : (gap == 8'hFF ? gap : gap + 8'h01);
            seen  <= cnt_wr ? 2'h0 : ((pass_done && seen != 2'h2) ? seen + 2'h1 : seen);
            quiet <= cnt_wr ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    a_pass_length: assert property (pass_done && seen == 2'h2 |-> gap == {1'b0, shadow})
        else $error("pass length differs from equation count");
    a_pass_ontime: assert property (seen == 2'h2 && gap == {1'b0, shadow} |-> pass_done)
        else $error("pass end pulse missing");
    a_zero_quiet: assert property (shadow == 7'h00 && quiet == 2'h3 |-> !pass_done && eq_unlatched == '0)
        else $error("equations run with count zero");
    a_out_range: assert property (seen == 2'h2 |-> ((eq_unlatched | eq_latched) & hi_mask) == '0)
        else $error("equation beyond count is active");
    a_one_change: assert property (seen == 2'h2 |->
        $onehot0((eq_unlatched ^ $past(eq_unlatched)) | (eq_latched ^ $past(eq_latched))))
        else $error("more than one equation changed in a cycle");
    a_reset_rise: assert property ($fell(srst) |-> eq_unlatched == '0 ##1 eq_unlatched[0] && eq_latched[0]
        && !eq_unlatched[1] ##1 eq_unlatched[1] ##1 eq_unlatched[2])
        else $error("default equations did not rise in order");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read answer");
    a_rdata_hole: assert property ($past(reg_rd) && $past(reg_addr) == 12'h008 |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== verif/le_sig_src.sv
`timescale 1ns/1ps
`default_nettype none
module le_sig_src #(
    parameter int EXT_N = 32
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // Wanted levels
    input  wire logic [EXT_N-1:0] want,
    // Levels toward the equations
    output var  logic [EXT_N-1:0] ext_sig
);
    // Protection outputs are registered levels, so they lag the request by a cycle
    always_ff @(posedge core_clk) begin
        ext_sig <= srst ? '0 : want;
    end
endmodule
`default_nettype wire

// ===== verif/le_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module le_bank_bench;
    logic        core_clk;
    logic        srst;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] want;
    logic [31:0] ext_sig;
    logic [79:0] eq_unlatched;
    logic [79:0] eq_latched;
    logic        pass_done;
    logic [1:0]  g;
    logic [3:0]  iv;
    logic [31:0] sl;
    logic [6:0]  cnt_tab [6] = '{7'h00, 7'h05, 7'h0A, 7'h14, 7'h28, 7'h50};
    int          bad_count;
    int          total_checks;
    int          seed;
    int          cycles;
    int          passes;
    le_bank u_le_bank (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_sig(ext_sig),
        .eq_unlatched(eq_unlatched), .eq_latched(eq_latched), .pass_done(pass_done));
    le_sig_src u_le_sig_src (.core_clk(core_clk), .srst(srst), .want(want), .ext_sig(ext_sig));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    function automatic logic [11:0] eq_a(input int n, input logic [2:0] f);
        return le_pkg::LE_EQ_BASE + 12'(n << le_pkg::LE_EQ_SHIFT) + {7'h00, f, 2'h0};
    endfunction
    task automatic wait_pass();
        do begin
            @(posedge core_clk);
            #1;
        end while (pass_done !== 1'b1);
    endtask
    task automatic set_want(input logic [31:0] v);
        @(posedge core_clk);
        want <= v;
    endtask
    // Unassigned inputs drop out, so they are neutral for every gate
    function automatic logic gate_out(input logic [1:0] gt, input logic [3:0] inv, input logic [31:0] s,
                                      input logic [31:0] e);
        logic       a;
        logic       o;
        logic [7:0] c;
        a = 1'b1;
        o = 1'b0;
        for (int i = 0; i < 4; i++) begin
            c = s[8*i +: 8];
            if (c != 8'h00) begin
                a = a & (e[c-8'h01] ^ inv[i]);
                o = o | (e[c-8'h01] ^ inv[i]);
            end
        end
        return gt[0] ? (o ^ gt[1]) : (a ^ gt[1]);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (pass_done === 1'b1) begin
            passes++;
        end
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        {srst, reg_wr, reg_rd, reg_addr, reg_wdata, want} = {1'b1, 78'h0};
        seed = 4;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(le_pkg::LE_REG_EQ_COUNT, 32'h14);
        rd(12'h008, 32'h0);
        wr(le_pkg::LE_REG_EQ_COUNT, 32'h7);
        rd(le_pkg::LE_REG_EQ_COUNT, 32'h14);
        foreach (cnt_tab[i]) begin
            wr(le_pkg::LE_REG_EQ_COUNT, {25'h0, cnt_tab[i]});
            rd(le_pkg::LE_REG_EQ_COUNT, {25'h0, cnt_tab[i]});
            if (i == 0) begin
                repeat (6) @(posedge core_clk);
                check(eq_unlatched, 80'h0);
            end
        end
        wr(le_pkg::LE_REG_EQ_COUNT, 32'h5);
        wait_pass();
        // The pulse just seen is already in the counter but not yet in passes
        rd(le_pkg::LE_REG_PASS, passes + 1);
        for (int k = 0; k < 12; k++) begin
            g  = k[1:0];
            iv = 4'($random(seed));
            for (int i = 0; i < 4; i++) sl[8*i +: 8] = 8'($unsigned($random(seed)) % 5);
            wr(eq_a(0, le_pkg::LE_F_CTRL), {26'h0, iv, g});
            wr(eq_a(0, le_pkg::LE_F_SEL), sl);
            set_want($random(seed));
            wait_pass();
            wait_pass();
            check(eq_unlatched[0], gate_out(g, iv, sl, want));
            rd(eq_a(0, le_pkg::LE_F_STAT), {30'h0, 1'b1, gate_out(g, iv, sl, want)});
            rd(eq_a(0, le_pkg::LE_F_CTRL), {26'h0, iv, g});
            rd(eq_a(0, le_pkg::LE_F_SEL), sl);
        end
        // Cascade: eq1 reads eq0 upward, eq2 reads eq3 downward
        for (int n = 0; n < 4; n++) begin
            wr(eq_a(n, le_pkg::LE_F_CTRL), 32'h1);
            wr(eq_a(n, le_pkg::LE_F_SEL), (n == 1) ? 32'h21 : ((n == 2) ? 32'h24 : 32'h1));
        end
        set_want(32'h0);
        wait_pass();
        wait_pass();
        set_want(32'h1);
        wait_pass();
        check(eq_unlatched[3:0], 4'b1000);
        wait_pass();
        check(eq_unlatched[3:0], 4'b1111);
        // Timer and latch on eq4
        wr(eq_a(4, le_pkg::LE_F_CTRL), 32'h1);
        wr(eq_a(4, le_pkg::LE_F_SEL), 32'h2);
        wr(eq_a(4, le_pkg::LE_F_RST), 32'h3);
        wr(eq_a(4, le_pkg::LE_F_ON), 32'h2);
        wr(eq_a(4, le_pkg::LE_F_OFF), 32'h1);
        rd(eq_a(4, le_pkg::LE_F_ON), 32'h2);
        rd(eq_a(4, le_pkg::LE_F_RST), 32'h3);
        set_want(32'h4);
        repeat (2) wait_pass();
        check(eq_latched[4], 1'b0);
        set_want(32'h0);
        repeat (2) wait_pass();
        set_want(32'h2);
        for (int p = 0; p < 3; p++) begin
            wait_pass();
            check(eq_unlatched[4], p == 2);
        end
        check(eq_latched[4], 1'b1);
        set_want(32'h0);
        wait_pass();
        check(eq_unlatched[4], 1'b1);
        wait_pass();
        check({eq_unlatched[4], eq_latched[4]}, 2'b01);
        wr(eq_a(4, le_pkg::LE_F_CTRL), 32'h81);
        repeat (2) wait_pass();
        check(eq_latched[4], 1'b0);
        set_want(32'h4);
        wr(eq_a(4, le_pkg::LE_F_CTRL), 32'hC1);
        repeat (2) wait_pass();
        check(eq_latched[4], 1'b1);
        // Latched output of eq4 as a source of eq3, seen one pass later
        wr(eq_a(3, le_pkg::LE_F_SEL), 32'h75);
        repeat (2) wait_pass();
        check(eq_unlatched[3], 1'b1);
        report_and_stop();
    end
endmodule
bind le_bank le_bank_monitor #(.MAX_EQ(MAX_EQ)) u_le_bank_monitor (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .eq_unlatched(eq_unlatched), .eq_latched(eq_latched), .pass_done(pass_done));
`default_nettype wire
